// >>> hdl/interrupt_enable_flag_logic.sv
// Notes on behaviour
// - Pin-change summary flag, bit 0, is set while any pin-change flag is set.
// - Summary flag is read-only; clears only after software clears all pin-change flags.
// - Every flag sets on its event whatever the enables say.
// - External-pin flag sits at bit 1; 1 means the event occurred.
// - Peripheral enable bit 6 gates the converter-complete request.
// - Peripheral enable bit 5 gates the serial receive request.
// - Peripheral enable register, converter bit included, resets to zero.
// - Global enable low blocks requests; pending ones are served once set again.
// - External flag sets on rising edge when edge-select is 1, falling when 0.
// - Taking an interrupt clears global enable and loads vector 0004h.
// - Return from interrupt sets global enable again.
//
// Design decisions made here: the register offsets and the APB register port.
`default_nettype none
`include "irq_regs.svh"

module interrupt_enable_flag_logic #(
  parameter int PIN_CHANGE_COUNT = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire irq_pkg::addr_type paddr,
  input wire irq_pkg::word_type pwdata,
  output irq_pkg::word_type prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_zero_overflow_evt,
  input wire logic external_irq_pin,
  input wire logic [PIN_CHANGE_COUNT-1:0] pin_change_pins,
  input wire irq_pkg::reg8_type peripheral_flags,
  input wire logic core_irq_ack,
  input wire logic return_from_interrupt,
  output logic core_irq_request,
  output logic vector_load,
  output irq_pkg::pc_type vector_addr,
  output logic irq_out
);
  import irq_pkg::*;

  // ==========================================================
  // Declarations
  reg_bus_if bus ();
  logic ext_rise, ext_fall;
  logic [PIN_CHANGE_COUNT-1:0] pc_rise, pc_fall;
  reg8_type interrupt_control_q, interrupt_control_d;
  reg8_type peripheral_interrupt_enable_one_q, peripheral_interrupt_enable_one_d;
  logic edge_sel_q, edge_sel_d;
  logic [PIN_CHANGE_COUNT-1:0] pc_flags_q, pc_flags_d;
  evt_type status_q, status_d;
  evt_type mask_q, mask_d;
  logic vector_load_q, vector_load_d;
  logic ext_event, pc_event, summary, take;
  evt_type events;

  if (PIN_CHANGE_COUNT < 1 || PIN_CHANGE_COUNT > 8) begin : g_bad_count
    $error("PIN_CHANGE_COUNT must be 1 to 8");
  end

  function automatic logic is_reg(input addr_type a, input addr_type off);
    return a == off;
  endfunction

  // ==========================================================
  // Bus port and pin synchronisers
  apb_reg_port u_port (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus.port)
  );

  pin_sync #(.WIDTH(1)) u_ext_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .pin(external_irq_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  pin_sync #(.WIDTH(PIN_CHANGE_COUNT)) u_pc_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .pin(pin_change_pins),
    .rise(pc_rise),
    .fall(pc_fall)
  );

  // ==========================================================
  // Request combining
  always_comb begin
    ext_event = edge_sel_q ? ext_rise : ext_fall;
    pc_event = |(pc_rise | pc_fall);
    summary = |pc_flags_q;
    // Flags stay set while global enable is low, so they are served later
    core_irq_request = interrupt_control_q[`BIT_GLOBAL_IRQ_ENABLE] & (
      (interrupt_control_q[`BIT_TIMER_ZERO_OVERFLOW_ENABLE] & interrupt_control_q[`BIT_TIMER_ZERO_OVERFLOW_FLAG]) |
      (interrupt_control_q[`BIT_EXTERNAL_PIN_IRQ_ENABLE] & interrupt_control_q[`BIT_EXTERNAL_PIN_IRQ_FLAG]) |
      (interrupt_control_q[`BIT_PIN_CHANGE_IRQ_ENABLE] & summary) |
      (interrupt_control_q[`BIT_PERIPHERAL_IRQ_ENABLE] & (|(peripheral_interrupt_enable_one_q & peripheral_flags))));
    take = clk_en & core_irq_ack & core_irq_request;
    events = '0;
    events[`EVT_TIMER_ZERO] = clk_en & timer_zero_overflow_evt;
    events[`EVT_EXTERNAL_PIN] = ext_event;
    events[`EVT_PIN_CHANGE] = pc_event;
    events[`EVT_VECTOR_TAKEN] = take;
    vector_load = vector_load_q;
    vector_addr = `IRQ_VECTOR_ADDR;
    irq_out = |(status_q & mask_q);
  end

  // ==========================================================
  // Register read decode
  always_comb begin
    bus.rdata = `RST_WORD32;
    bus.hit = 1'b1;
    if (is_reg(bus.addr, `OFF_INTERRUPT_CONTROL)) begin
      bus.rdata[7:0] = interrupt_control_q;
      bus.rdata[`BIT_PIN_CHANGE_SUMMARY_FLAG] = summary;
    end else if (is_reg(bus.addr, `OFF_PERIPHERAL_ENABLE_ONE)) begin
      bus.rdata[7:0] = peripheral_interrupt_enable_one_q;
    end else if (is_reg(bus.addr, `OFF_OPTION)) begin
      bus.rdata[`BIT_EXTERNAL_EDGE_SELECT] = edge_sel_q;
    end else if (is_reg(bus.addr, `OFF_PIN_CHANGE_FLAGS)) begin
      bus.rdata[PIN_CHANGE_COUNT-1:0] = pc_flags_q;
    end else if (is_reg(bus.addr, `OFF_IRQ_STATUS)) begin
      bus.rdata[3:0] = status_q;
    end else if (is_reg(bus.addr, `OFF_IRQ_MASK)) begin
      bus.rdata[3:0] = mask_q;
    end else begin
      bus.hit = 1'b0;
    end
  end

  // ==========================================================
  // Next-state logic; hardware set always wins over a software clear
  always_comb begin
    interrupt_control_d = interrupt_control_q;
    peripheral_interrupt_enable_one_d = peripheral_interrupt_enable_one_q;
    edge_sel_d = edge_sel_q;
    pc_flags_d = pc_flags_q;
    status_d = status_q;
    mask_d = mask_q;
    vector_load_d = clk_en ? take : vector_load_q;
    if (bus.wr && is_reg(bus.addr, `OFF_INTERRUPT_CONTROL)) begin
      // Summary bit is not stored from the bus: it is read-only
      interrupt_control_d[7:1] = bus.wdata[7:1];
    end
    if (bus.wr && is_reg(bus.addr, `OFF_PERIPHERAL_ENABLE_ONE)) begin
      peripheral_interrupt_enable_one_d = bus.wdata[7:0];
    end
    if (bus.wr && is_reg(bus.addr, `OFF_OPTION)) begin
      edge_sel_d = bus.wdata[`BIT_EXTERNAL_EDGE_SELECT];
    end
    if (bus.wr && is_reg(bus.addr, `OFF_PIN_CHANGE_FLAGS)) begin
      // Writing 0 clears a flag, writing 1 leaves it
      pc_flags_d = pc_flags_q & bus.wdata[PIN_CHANGE_COUNT-1:0];
    end
    if (bus.wr && is_reg(bus.addr, `OFF_IRQ_STATUS)) begin
      status_d = status_q & ~bus.wdata[3:0];
    end
    if (bus.wr && is_reg(bus.addr, `OFF_IRQ_MASK)) begin
      mask_d = bus.wdata[3:0];
    end
    pc_flags_d = pc_flags_d | pc_rise | pc_fall;
    if (events[`EVT_TIMER_ZERO]) begin
      interrupt_control_d[`BIT_TIMER_ZERO_OVERFLOW_FLAG] = 1'b1;
    end
    if (ext_event) begin
      interrupt_control_d[`BIT_EXTERNAL_PIN_IRQ_FLAG] = 1'b1;
    end
    if (clk_en && return_from_interrupt) begin
      interrupt_control_d[`BIT_GLOBAL_IRQ_ENABLE] = 1'b1;
    end
    // Acceptance wins if both arrive together, so no request slips past
    if (take) begin
      interrupt_control_d[`BIT_GLOBAL_IRQ_ENABLE] = 1'b0;
    end
    interrupt_control_d[`BIT_PIN_CHANGE_SUMMARY_FLAG] = 1'b0;
    status_d = status_d | events;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_control_q <= `RST_REG8;
      peripheral_interrupt_enable_one_q <= `RST_REG8;
      edge_sel_q <= 1'b0;
      pc_flags_q <= '0;
      status_q <= `RST_EVT4;
      mask_q <= `RST_EVT4;
      vector_load_q <= 1'b0;
    end else begin
      interrupt_control_q <= interrupt_control_d;
      peripheral_interrupt_enable_one_q <= peripheral_interrupt_enable_one_d;
      edge_sel_q <= edge_sel_d;
      pc_flags_q <= pc_flags_d;
      status_q <= status_d;
      mask_q <= mask_d;
      vector_load_q <= vector_load_d;
    end
  end
endmodule

`default_nettype wire

// >>> hdl/irq_regs.svh
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

// ==========================================================
// Register byte offsets
`define OFF_INTERRUPT_CONTROL 8'h00
`define OFF_PERIPHERAL_ENABLE_ONE 8'h04
`define OFF_OPTION 8'h08
`define OFF_PIN_CHANGE_FLAGS 8'h0C
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14

// ==========================================================
// Interrupt control bit positions
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_TIMER_ZERO_OVERFLOW_ENABLE 5
`define BIT_EXTERNAL_PIN_IRQ_ENABLE 4
`define BIT_PIN_CHANGE_IRQ_ENABLE 3
`define BIT_TIMER_ZERO_OVERFLOW_FLAG 2
`define BIT_EXTERNAL_PIN_IRQ_FLAG 1
`define BIT_PIN_CHANGE_SUMMARY_FLAG 0

// ==========================================================
// Peripheral enable one bit positions
`define BIT_TIMER_ONE_GATE_IRQ_ENABLE 7
`define BIT_CONVERTER_IRQ_ENABLE 6
`define BIT_SERIAL_RECEIVE_IRQ_ENABLE 5
`define BIT_SERIAL_TRANSMIT_IRQ_ENABLE 4
`define BIT_SYNC_SERIAL_IRQ_ENABLE 3
`define BIT_CAPTURE_UNIT_IRQ_ENABLE 2
`define BIT_TIMER_TWO_MATCH_IRQ_ENABLE 1
`define BIT_TIMER_ONE_OVERFLOW_ENABLE 0

// ==========================================================
// Option and status bit positions
`define BIT_EXTERNAL_EDGE_SELECT 0
`define EVT_TIMER_ZERO 0
`define EVT_EXTERNAL_PIN 1
`define EVT_PIN_CHANGE 2
`define EVT_VECTOR_TAKEN 3

// ==========================================================
// Reset values and constants
`define RST_REG8 8'h00
`define RST_EVT4 4'h0
`define RST_WORD32 32'h0000_0000
`define IRQ_VECTOR_ADDR 16'h0004

`endif

// >>> hdl/irq_pkg.sv
`default_nettype none

package irq_pkg;
  typedef logic [7:0] reg8_type;
  typedef logic [7:0] addr_type;
  typedef logic [31:0] word_type;
  typedef logic [3:0] evt_type;
  typedef logic [15:0] pc_type;
endpackage

`default_nettype wire

// >>> hdl/reg_bus_if.sv
`default_nettype none

// ==========================================================
// Register access between the bus port and the block core
interface reg_bus_if;
  import irq_pkg::*;
  logic wr;
  addr_type addr;
  word_type wdata;
  word_type rdata;
  logic hit;
  modport port (output wr, output addr, output wdata, input rdata, input hit);
  modport core (input wr, input addr, input wdata, output rdata, output hit);
endinterface

`default_nettype wire

// >>> hdl/pin_sync.sv
`default_nettype none
`include "irq_regs.svh"

// ==========================================================
// Two-stage synchroniser with edge detect, one per pin
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q, meta_d;
  logic [WIDTH-1:0] sync_q, sync_d;
  logic [WIDTH-1:0] prev_q, prev_d;

  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("pin_sync WIDTH must be 1 to 32");
  end

  // Edges are judged only on the second stage, never on the metastable first
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      meta_d[i] = clk_en ? pin[i] : meta_q[i];
      sync_d[i] = clk_en ? meta_q[i] : sync_q[i];
      prev_d[i] = clk_en ? sync_q[i] : prev_q[i];
      rise[i] = clk_en & sync_q[i] & ~prev_q[i];
      fall[i] = clk_en & ~sync_q[i] & prev_q[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end
endmodule

`default_nettype wire

// >>> hdl/apb_reg_port.sv
`default_nettype none
`include "irq_regs.svh"

// ==========================================================
// APB slave: zero wait states while clk_en is high, read data captured in setup
module apb_reg_port (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire irq_pkg::addr_type paddr,
  input wire irq_pkg::word_type pwdata,
  output irq_pkg::word_type prdata,
  output logic pready,
  output logic pslverr,
  reg_bus_if.port bus
);
  import irq_pkg::*;
  word_type rdata_q, rdata_d;
  logic err_q, err_d;

  always_comb begin
    bus.addr = paddr;
    bus.wdata = pwdata;
    // A write takes effect only at the edge that completes the access
    bus.wr = clk_en & psel & penable & pwrite & bus.hit;
    rdata_d = rdata_q;
    err_d = err_q;
    if (clk_en && psel && !penable) begin
      rdata_d = (!pwrite && bus.hit) ? bus.rdata : `RST_WORD32;
      err_d = ~bus.hit;
    end
    // Frozen clock enable stalls the access rather than losing it
    pready = clk_en;
    pslverr = psel & penable & err_q;
    prdata = rdata_q;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= `RST_WORD32;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end
endmodule

`default_nettype wire

// >>> verification/irq_asserts.sv
`default_nettype none
// ==========================================================
// Checker on the top ports
module irq_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic core_irq_ack,
  input wire logic core_irq_request,
  input wire logic return_from_interrupt,
  input wire logic vector_load,
  input wire irq_pkg::pc_type vector_addr
);
  import irq_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_take;
    core_irq_ack && core_irq_request && clk_en;
  endsequence
  sequence s_vector;
    vector_load && !core_irq_request;
  endsequence
  a_take_vector: assert property (s_take |=> s_vector)
    else $error("ack did not load the vector");
  a_vector_cause: assert property (vector_load |-> $past(core_irq_ack && core_irq_request && clk_en))
    else $error("vector load without accepted ack");
  a_vector_value: assert property (vector_load |-> vector_addr == 16'h0004)
    else $error("wrong vector address");
  a_vector_once: assert property (vector_load |=> !vector_load)
    else $error("vector load longer than one cycle");
  a_ack_refused: assert property (core_irq_ack && !core_irq_request |=> !vector_load)
    else $error("ack without request was taken");
  a_gie_stays_low: assert property (s_take ##1 (!return_from_interrupt && !psel) [*3] |-> !core_irq_request)
    else $error("request back before return");
  a_ready_zero: assert property (psel && penable |-> pready == clk_en)
    else $error("access phase not answered at once");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule

bind interrupt_enable_flag_logic irq_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .core_irq_ack(core_irq_ack),
  .core_irq_request(core_irq_request), .return_from_interrupt(return_from_interrupt),
  .vector_load(vector_load), .vector_addr(vector_addr));
`default_nettype wire

// >>> verification/core_model.sv
`default_nettype none
// ==========================================================
// Core: takes a request, serves it, then returns
module core_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic core_irq_request,
  input wire logic vector_load,
  output logic core_irq_ack,
  output logic return_from_interrupt
);
  logic [2:0] cnt_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      core_irq_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      // Ack only a live request, one pulse
      core_irq_ack <= go && core_irq_request && !core_irq_ack;
      cnt_q <= vector_load ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
      return_from_interrupt <= cnt_q == 3'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/interrupt_enable_flag_logic_tb.sv
`default_nettype none
module interrupt_enable_flag_logic_tb;
  import irq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rstn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic tz = 0, ext = 0, ack, rfi, go = 0, req, vload, irq, pready, pslverr;
  logic [7:0] pcp = 8'h00;
  reg8_type pfl = 8'h00;
  addr_type paddr = 8'h00;
  word_type pwdata = 32'h0, prdata;
  pc_type vaddr;
  int n_mismatch = 0, tests_run = 0, n;
  word_type exp_q[$];
  logic [31:0] rnd = 32'h1743B7B9;
  interrupt_enable_flag_logic u_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_zero_overflow_evt(tz), .external_irq_pin(ext), .pin_change_pins(pcp),
    .peripheral_flags(pfl), .core_irq_ack(ack), .return_from_interrupt(rfi), .core_irq_request(req),
    .vector_load(vload), .vector_addr(vaddr), .irq_out(irq));
  core_model u_core (.sys_clk(sys_clk), .rstn(rstn), .go(go), .core_irq_request(req),
    .vector_load(vload), .core_irq_ack(ack), .return_from_interrupt(rfi));
  // ==========================================================
  // Tasks
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task conclude;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input word_type s, input word_type e);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      n_mismatch++;
    end
  endtask
  task lim(input logic ok);
    if (!ok) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // Idle edge at the end so the next setup never lands in the same step
  task apb(input logic w, input addr_type a, input word_type d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!pready && n < 20);
    lim(pready);
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task wr(input addr_type a, input word_type d);
    apb(1, a, d);
  endtask
  task rd(input addr_type a, input word_type e);
    exp_q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  task cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk)
    if (psel && penable && pready && !pwrite) chk(prdata, exp_q.pop_front());
  // ==========================================================
  // Scenarios
  initial begin
    cyc(16);
    rstn <= 1;
    cyc(1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rnd = lfsr(rnd);
    wr(8'h04, rnd);
    rd(8'h04, {24'h0, rnd[7:0]});
    wr(8'h00, 32'hC0);
    for (int b = 5; b < 7; b++) begin
      pfl <= 8'h01 << b;
      wr(8'h04, 32'h0);
      chk({31'h0, req}, 32'h0);
      wr(8'h04, 32'h1 << b);
      chk({31'h0, req}, 32'h1);
    end
    wr(8'h00, 32'h80);
    chk({31'h0, req}, 32'h0);
    wr(8'h00, 32'h40);
    chk({31'h0, req}, 32'h0);
    wr(8'h00, 32'hC0);
    chk({31'h0, req}, 32'h1);
    pfl <= 8'h00;
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h1);
    ext <= 1;
    cyc(6);
    rd(8'h00, 32'h02);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    ext <= 0;
    cyc(6);
    rd(8'h00, 32'h02);
    wr(8'h00, 32'h0);
    pcp <= 8'h10;
    cyc(6);
    rd(8'h00, 32'h01);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h01);
    rd(8'h0C, 32'h10);
    wr(8'h0C, 32'h0);
    rd(8'h00, 32'h0);
    wr(8'h10, 32'hF);
    tz <= 1;
    @(posedge sys_clk) tz <= 0;
    rd(8'h00, 32'h04);
    go <= 1;
    // Keep the timer-zero flag set while enabling, or no request is raised
    wr(8'h00, 32'hA4);
    n = 0;
    do @(negedge sys_clk); while (!vload && ++n < 20);
    lim(vload);
    @(posedge sys_clk) go <= 0;
    rd(8'h00, 32'h24);
    rd(8'h10, 32'h09);
    cyc(4);
    rd(8'h00, 32'hA4);
    chk({31'h0, req}, 32'h1);
    wr(8'h14, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(8'h10, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
